// ---- itf_pkg.sv ----
// Constants shared by the input terminal function logic.
package itf_pkg;
    localparam int NUM_IN = 7;
    localparam int NUM_FN = 11;
    localparam int ADDR_W = 12;
    localparam int LIM_W  = 16;

    // Terminal function codes as set in the per-input function registers.
    localparam logic [7:0] FN_SRC_DIGITAL  = 8'h33;
    localparam logic [7:0] FN_SRC_AI1      = 8'h34;
    localparam logic [7:0] FN_SRC_AI2      = 8'h35;
    localparam logic [7:0] FN_SRC_PULSE    = 8'h37;
    localparam logic [7:0] FN_SRC_COMM     = 8'h38;
    localparam logic [7:0] FN_RUN_ENABLE   = 8'h39;
    localparam logic [7:0] FN_REV_OVERRIDE = 8'h44;
    localparam logic [7:0] FN_REV_PROHIBIT = 8'h45;
    localparam logic [7:0] FN_CUTOFF       = 8'h79;
    localparam logic [7:0] FN_WIRING       = 8'h7a;
    localparam logic [7:0] FN_BRAKE_RESET  = 8'h7b;
    localparam logic [7:0] FN_CODES [NUM_FN] = '{
        FN_SRC_DIGITAL, FN_SRC_AI1, FN_SRC_AI2, FN_SRC_PULSE,
        FN_SRC_COMM, FN_RUN_ENABLE, FN_REV_OVERRIDE,
        FN_REV_PROHIBIT, FN_CUTOFF, FN_WIRING, FN_BRAKE_RESET};
    localparam int FI_SRC_DIGITAL  = 0;
    localparam int FI_SRC_AI1      = 1;
    localparam int FI_SRC_AI2      = 2;
    localparam int FI_SRC_PULSE    = 3;
    localparam int FI_SRC_COMM     = 4;
    localparam int FI_RUN_ENABLE   = 5;
    localparam int FI_REV_OVERRIDE = 6;
    localparam int FI_REV_PROHIBIT = 7;
    localparam int FI_CUTOFF       = 8;
    localparam int FI_WIRING       = 9;
    localparam int FI_BRAKE_RESET  = 10;

    // Main frequency source codes driven on main_source_o.
    localparam logic [2:0] SRC_DIGITAL = 3'h1;
    localparam logic [2:0] SRC_AI1     = 3'h2;
    localparam logic [2:0] SRC_AI2     = 3'h3;
    localparam logic [2:0] SRC_PULSE   = 3'h5;
    localparam logic [2:0] SRC_COMM    = 3'h6;

    localparam logic [1:0] OVR_NONE  = 2'h0;
    localparam logic [1:0] OVR_MODE1 = 2'h1;
    localparam logic [1:0] OVR_MODE2 = 2'h2;

    localparam logic [11:0] ADDR_POL_CONTACT = 12'h000;
    localparam logic [11:0] ADDR_POL_ANALOG  = 12'h004;
    localparam logic [11:0] ADDR_FUNC_BASE   = 12'h008;
    localparam logic [11:0] ADDR_STRIDE      = 12'h004;
    localparam logic [11:0] ADDR_CTRL        = 12'h024;
    localparam logic [11:0] ADDR_STATUS      = 12'h028;
    localparam logic [11:0] ADDR_IRQ_STAT    = 12'h02c;
    localparam logic [11:0] ADDR_IRQ_MASK    = 12'h030;
    localparam logic [11:0] ADDR_WIRE_VALID  = 12'h034;
    localparam logic [11:0] ADDR_WIRE_INVAL  = 12'h038;

    localparam int CTRL_SRC_LSB   = 0;
    localparam int CTRL_MAIN_ACT  = 4;
    localparam int CTRL_MULTISTEP = 5;
    localparam int CTRL_REV_PROH  = 6;
    localparam int CTRL_OVR_LSB   = 8;
    localparam int CTRL_CUT_EXT   = 10;
    localparam int CTRL_W         = 11;

    localparam int IRQ_CUTOFF = 0;
    localparam int IRQ_WIRING = 1;
    localparam int IRQ_BRAKE  = 2;
    localparam int IRQ_W      = 3;

    localparam logic [4:0]        POL_C_RST = 5'h00;
    localparam logic [1:0]        POL_A_RST = 2'h0;
    localparam logic [CTRL_W-1:0] CTRL_RST  = 11'h000;
    localparam logic [LIM_W-1:0]  LIM_RST   = 16'h0000;
endpackage : itf_pkg

// ---- itf_term_decode.sv ----
// Polarity and terminal function decoding for all logic inputs.
`timescale 1ns/100ps
`default_nettype none
module itf_term_decode #(
    parameter int NI = itf_pkg::NUM_IN,
    parameter int NF = itf_pkg::NUM_FN
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic [NI-1:0]         raw_i,
    input  wire logic [NI-1:0]         pol_i,
    input  wire logic [NI-1:0][7:0]    func_i,
    output logic      [NI-1:0]         valid_o,
    output logic      [NF-1:0][NI-1:0] assigned_o,
    output logic      [NF-1:0][NI-1:0] active_o
);
    typedef struct packed {
        logic [NI-1:0]         valid;
        logic [NF-1:0][NI-1:0] asg;
        logic [NF-1:0][NI-1:0] act;
    } itf_dec_s;
    itf_dec_s s_r;
    itf_dec_s s_nxt;
    logic [NI-1:0] sense;

    // Polarity is applied first so every function sees the valid level.
    assign sense = raw_i ^ pol_i;

    always_comb
    begin
        s_nxt       = s_r;
        s_nxt.valid = sense;
        for (int f = 0; f < NF; f++)
        begin
            for (int i = 0; i < NI; i++)
            begin
                s_nxt.asg[f][i] = (func_i[i] == itf_pkg::FN_CODES[f]);
                s_nxt.act[f][i] = s_nxt.asg[f][i] & sense[i];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign valid_o    = s_r.valid;
    assign assigned_o = s_r.asg;
    assign active_o   = s_r.act;

    chk_pol_sense: assert property (@(posedge clk_i) disable iff (rst_i)
        (pol_i[0] != raw_i[0]) |=> valid_o[0])
        else $error("inverted input not seen as valid");
endmodule : itf_term_decode
`default_nettype wire

// ---- itf_hold_timer.sv ----
// Dwell timer that flags a signal standing valid or invalid too long.
`timescale 1ns/100ps
`default_nettype none
module itf_hold_timer #(
    parameter int W = itf_pkg::LIM_W
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         arm_i,
    input  wire logic         sig_i,
    input  wire logic [W-1:0] valid_lim_i,
    input  wire logic [W-1:0] inval_lim_i,
    output logic              fault_o
);
    typedef struct packed {
        logic         prev;
        logic [W-1:0] cnt;
        logic         fault;
    } itf_tmr_s;
    itf_tmr_s     s_r;
    itf_tmr_s     s_nxt;
    logic [W-1:0] lim;
    logic [W-1:0] inc;

    assign lim = sig_i ? valid_lim_i : inval_lim_i;
    assign inc = s_r.cnt + {{(W-1){1'b0}}, 1'b1};

    // A limit of zero disables the check; the count saturates so it fires once.
    always_comb
    begin
        s_nxt       = s_r;
        s_nxt.prev  = sig_i;
        s_nxt.fault = 1'b0;
        if (!arm_i || sig_i != s_r.prev)
            s_nxt.cnt = '0;
        else if (s_r.cnt != '1)
            s_nxt.cnt = inc;
        if (arm_i && sig_i == s_r.prev && lim != '0 && inc == lim)
            s_nxt.fault = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign fault_o = s_r.fault;

    chk_wire_fire: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_o |-> $past(arm_i) && $past(lim) != '0 && $past(inc) == $past(lim))
        else $error("dwell fault without limit reached");
endmodule : itf_hold_timer
`default_nettype wire

// ---- itf_input_logic.sv ----
// Top of the input terminal function logic with its APB register file.
`timescale 1ns/100ps
`default_nettype none
module itf_input_logic #(
    parameter int NI = itf_pkg::NUM_IN,
    parameter int NF = itf_pkg::NUM_FN,
    parameter int LW = itf_pkg::LIM_W
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        contact_input_one_i,
    input  wire logic        contact_input_two_i,
    input  wire logic        contact_input_three_i,
    input  wire logic        contact_input_four_i,
    input  wire logic        contact_input_five_i,
    input  wire logic        analog_input_one_i,
    input  wire logic        analog_input_two_i,
    input  wire logic        run_cond_i,
    input  wire logic        brake_trig_i,
    output logic      [2:0]  main_source_o,
    output logic             run_allowed_o,
    output logic             reverse_allowed_o,
    output logic             brake_o,
    output logic             material_cutoff_fault_o,
    output logic             wiring_detect_fault_o,
    output logic             irq_o
);
    typedef struct packed {
        logic [4:0]                         pol_c;
        logic [1:0]                         pol_a;
        logic [NI-1:0][7:0]                 func;
        logic [itf_pkg::CTRL_W-1:0]         ctrl;
        logic [LW-1:0]                      wv;
        logic [LW-1:0]                      wi;
        logic [itf_pkg::IRQ_W-1:0]          irq_st;
        logic [itf_pkg::IRQ_W-1:0]          irq_mask;
        logic                               brake;
        logic [2:0]                         src;
        logic                               run_ok;
        logic                               rev_ok;
        logic [31:0]                        rdata;
        logic                               slverr;
    } itf_top_s;

    itf_top_s                s_r;
    itf_top_s                s_nxt;
    logic [NI-1:0]           raw;
    logic [NI-1:0]           pol;
    logic [NI-1:0]           valid;
    logic [NF-1:0][NI-1:0]   asg;
    logic [NF-1:0][NI-1:0]   act;
    logic [NI-1:0]           wire_flt;
    logic [NF-1:0]           any_act;
    logic                    sw_any;
    logic                    sw_take;
    logic [2:0]              pick;
    logic                    run_en;
    logic                    prohibit;
    logic                    rev_ok;
    logic [1:0]              ovr;
    logic [itf_pkg::IRQ_W-1:0] ev;
    logic                    setup;
    logic                    wr;
    logic [31:0]             rd;
    logic                    hit;
    logic [11:0]             fa;

    ////////////////////////////////////////////////////////////////////////////////
    // Terminal decode and wiring timers.

    assign raw = {analog_input_two_i, analog_input_one_i, contact_input_five_i,
                  contact_input_four_i, contact_input_three_i,
                  contact_input_two_i, contact_input_one_i};
    assign pol = {s_r.pol_a, s_r.pol_c};

    itf_term_decode #(
        .NI (NI),
        .NF (NF)
    ) u_dec (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .raw_i      (raw),
        .pol_i      (pol),
        .func_i     (s_r.func),
        .valid_o    (valid),
        .assigned_o (asg),
        .active_o   (act)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NI; gi++)
        begin : g_wire
            itf_hold_timer #(
                .W (LW)
            ) u_tmr (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .arm_i       (asg[itf_pkg::FI_WIRING][gi]),
                .sig_i       (valid[gi]),
                .valid_lim_i (s_r.wv),
                .inval_lim_i (s_r.wi),
                .fault_o     (wire_flt[gi])
            );
        end
        for (gi = 0; gi < NF; gi++)
        begin : g_any
            assign any_act[gi] = |act[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Terminal functions.

    assign sw_any = any_act[itf_pkg::FI_SRC_DIGITAL] | any_act[itf_pkg::FI_SRC_AI1]
                  | any_act[itf_pkg::FI_SRC_AI2] | any_act[itf_pkg::FI_SRC_PULSE]
                  | any_act[itf_pkg::FI_SRC_COMM];
    assign sw_take = s_r.ctrl[itf_pkg::CTRL_MAIN_ACT]
                   & ~s_r.ctrl[itf_pkg::CTRL_MULTISTEP] & sw_any;

    // Lower function code wins when several switch terminals are valid.
    always_comb
    begin
        pick = s_r.ctrl[itf_pkg::CTRL_SRC_LSB +: 3];
        if (sw_take)
        begin
            if (any_act[itf_pkg::FI_SRC_DIGITAL])
                pick = itf_pkg::SRC_DIGITAL;
            else if (any_act[itf_pkg::FI_SRC_AI1])
                pick = itf_pkg::SRC_AI1;
            else if (any_act[itf_pkg::FI_SRC_AI2])
                pick = itf_pkg::SRC_AI2;
            else if (any_act[itf_pkg::FI_SRC_PULSE])
                pick = itf_pkg::SRC_PULSE;
            else
                pick = itf_pkg::SRC_COMM;
        end
    end

    // An input not assigned to run enable cannot veto it, so none assigned reads valid.
    assign run_en = &(valid | ~asg[itf_pkg::FI_RUN_ENABLE]);

    assign prohibit = any_act[itf_pkg::FI_REV_PROHIBIT]
                    | s_r.ctrl[itf_pkg::CTRL_REV_PROH];
    assign ovr = s_r.ctrl[itf_pkg::CTRL_OVR_LSB +: 2];

    always_comb
    begin
        rev_ok = ~prohibit;
        if (ovr == itf_pkg::OVR_MODE1)
            rev_ok = prohibit & any_act[itf_pkg::FI_REV_OVERRIDE];
        else if (ovr == itf_pkg::OVR_MODE2)
            rev_ok = ~(prohibit & any_act[itf_pkg::FI_REV_OVERRIDE]);
    end

    always_comb
    begin
        ev = '0;
        ev[itf_pkg::IRQ_CUTOFF] = s_r.ctrl[itf_pkg::CTRL_CUT_EXT]
                                & any_act[itf_pkg::FI_CUTOFF];
        ev[itf_pkg::IRQ_WIRING] = |wire_flt;
        ev[itf_pkg::IRQ_BRAKE]  = s_r.brake & any_act[itf_pkg::FI_BRAKE_RESET];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: read data and error are sampled in the setup cycle.

    assign setup = psel_i & ~penable_i;
    assign wr    = psel_i & penable_i & pwrite_i;

    always_comb
    begin
        rd  = 32'h0000_0000;
        hit = 1'b1;
        fa  = 12'h000;
        if (paddr_i == itf_pkg::ADDR_POL_CONTACT)
            rd[4:0] = s_r.pol_c;
        else if (paddr_i == itf_pkg::ADDR_POL_ANALOG)
            rd[1:0] = s_r.pol_a;
        else if (paddr_i == itf_pkg::ADDR_CTRL)
            rd[itf_pkg::CTRL_W-1:0] = s_r.ctrl;
        else if (paddr_i == itf_pkg::ADDR_STATUS)
            rd = {16'h0000, 1'b0, valid, 2'b00, s_r.brake, s_r.rev_ok,
                  s_r.run_ok, s_r.src};
        else if (paddr_i == itf_pkg::ADDR_IRQ_STAT)
            rd[itf_pkg::IRQ_W-1:0] = s_r.irq_st;
        else if (paddr_i == itf_pkg::ADDR_IRQ_MASK)
            rd[itf_pkg::IRQ_W-1:0] = s_r.irq_mask;
        else if (paddr_i == itf_pkg::ADDR_WIRE_VALID)
            rd[LW-1:0] = s_r.wv;
        else if (paddr_i == itf_pkg::ADDR_WIRE_INVAL)
            rd[LW-1:0] = s_r.wi;
        else
        begin
            hit = 1'b0;
            for (int i = 0; i < NI; i++)
            begin
                fa = itf_pkg::ADDR_FUNC_BASE + (itf_pkg::ADDR_STRIDE * i[11:0]);
                if (paddr_i == fa)
                begin
                    rd[7:0] = s_r.func[i];
                    hit     = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.src    = pick;
        s_nxt.run_ok = run_cond_i & run_en;
        s_nxt.rev_ok = rev_ok;
        // A new brake request outranks a reset in the same cycle.
        s_nxt.brake  = brake_trig_i
                     | (s_r.brake & ~any_act[itf_pkg::FI_BRAKE_RESET]);
        if (setup)
        begin
            s_nxt.rdata  = rd;
            s_nxt.slverr = ~hit;
        end
        s_nxt.irq_st = s_r.irq_st;
        if (wr && paddr_i == itf_pkg::ADDR_POL_CONTACT)
            s_nxt.pol_c = pwdata_i[4:0];
        else if (wr && paddr_i == itf_pkg::ADDR_POL_ANALOG)
            s_nxt.pol_a = pwdata_i[1:0];
        else if (wr && paddr_i == itf_pkg::ADDR_CTRL)
            s_nxt.ctrl = pwdata_i[itf_pkg::CTRL_W-1:0];
        else if (wr && paddr_i == itf_pkg::ADDR_IRQ_STAT)
            s_nxt.irq_st = s_r.irq_st & ~pwdata_i[itf_pkg::IRQ_W-1:0];
        else if (wr && paddr_i == itf_pkg::ADDR_IRQ_MASK)
            s_nxt.irq_mask = pwdata_i[itf_pkg::IRQ_W-1:0];
        else if (wr && paddr_i == itf_pkg::ADDR_WIRE_VALID)
            s_nxt.wv = pwdata_i[LW-1:0];
        else if (wr && paddr_i == itf_pkg::ADDR_WIRE_INVAL)
            s_nxt.wi = pwdata_i[LW-1:0];
        else if (wr)
        begin
            for (int i = 0; i < NI; i++)
            begin
                if (paddr_i == itf_pkg::ADDR_FUNC_BASE + (itf_pkg::ADDR_STRIDE * i[11:0]))
                    s_nxt.func[i] = pwdata_i[7:0];
            end
        end
        // Events are OR-ed after the clear so a same-cycle event is kept.
        s_nxt.irq_st = s_nxt.irq_st | ev;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_r       <= '0;
            s_r.pol_c <= itf_pkg::POL_C_RST;
            s_r.pol_a <= itf_pkg::POL_A_RST;
            s_r.ctrl  <= itf_pkg::CTRL_RST;
            s_r.wv    <= itf_pkg::LIM_RST;
            s_r.wi    <= itf_pkg::LIM_RST;
        end
        else
            s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign prdata_o                = s_r.rdata;
    assign pready_o                = 1'b1;
    assign pslverr_o               = psel_i & penable_i & s_r.slverr;
    assign main_source_o           = s_r.src;
    assign run_allowed_o           = s_r.run_ok;
    assign reverse_allowed_o       = s_r.rev_ok;
    assign brake_o                 = s_r.brake;
    assign material_cutoff_fault_o = s_r.irq_st[itf_pkg::IRQ_CUTOFF];
    assign wiring_detect_fault_o   = s_r.irq_st[itf_pkg::IRQ_WIRING];
    assign irq_o                   = |(s_r.irq_st & s_r.irq_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_src_base: assert property (@(posedge clk_i) disable iff (rst_i)
        !s_r.ctrl[itf_pkg::CTRL_MAIN_ACT] |=> main_source_o == $past(s_r.ctrl[itf_pkg::CTRL_SRC_LSB +: 3]))
        else $error("main source switched while not taking part");

    chk_src_prio: assert property (@(posedge clk_i) disable iff (rst_i)
        (sw_take && any_act[itf_pkg::FI_SRC_DIGITAL] && any_act[itf_pkg::FI_SRC_COMM])
        |=> main_source_o == itf_pkg::SRC_DIGITAL)
        else $error("switch priority not honoured");

    chk_run_default: assert property (@(posedge clk_i) disable iff (rst_i)
        (asg[itf_pkg::FI_RUN_ENABLE] == '0 && run_cond_i) |=> run_allowed_o)
        else $error("unassigned run enable blocked running");

    chk_run_and: assert property (@(posedge clk_i) disable iff (rst_i)
        |(asg[itf_pkg::FI_RUN_ENABLE] & ~valid) |=> !run_allowed_o)
        else $error("invalid run enable terminal ignored");

    chk_run_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
        run_allowed_o |-> $past(run_cond_i) && $past(run_en))
        else $error("running allowed without enable");

    chk_rev_mode1: assert property (@(posedge clk_i) disable iff (rst_i)
        (ovr == itf_pkg::OVR_MODE1 && !any_act[itf_pkg::FI_REV_OVERRIDE])
        |=> !reverse_allowed_o)
        else $error("mode 1 allowed reverse without override");

    chk_rev_mode2: assert property (@(posedge clk_i) disable iff (rst_i)
        (ovr == itf_pkg::OVR_MODE2 && prohibit && any_act[itf_pkg::FI_REV_OVERRIDE])
        |=> !reverse_allowed_o)
        else $error("mode 2 failed to block reverse");

    chk_rev_prohibit: assert property (@(posedge clk_i) disable iff (rst_i)
        (ovr == itf_pkg::OVR_NONE && any_act[itf_pkg::FI_REV_PROHIBIT])
        |=> !reverse_allowed_o)
        else $error("prohibit terminal did not block reverse");

    chk_cutoff_raise: assert property (@(posedge clk_i) disable iff (rst_i)
        ev[itf_pkg::IRQ_CUTOFF] |=> material_cutoff_fault_o)
        else $error("cutoff fault not raised");

    chk_wire_raise: assert property (@(posedge clk_i) disable iff (rst_i)
        (|wire_flt) |=> wiring_detect_fault_o)
        else $error("wiring fault not raised");

    chk_brake_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        (brake_o && any_act[itf_pkg::FI_BRAKE_RESET] && !brake_trig_i) |=> !brake_o)
        else $error("brake not reset by terminal");
endmodule : itf_input_logic
`default_nettype wire

// ---- itf_switch_model.sv ----
// Behavioural model of the switches and sensors wired to the terminals.
`timescale 1ns/100ps
`default_nettype none
module itf_switch_model (
    input  wire logic [6:0] closed_i,
    output logic      [6:0] level_o
);
    // A closed contact pulls its terminal high; the bench picks which are closed.
    assign level_o = closed_i;
endmodule : itf_switch_model
`default_nettype wire

// ---- itf_input_logic_test.sv ----
// Self-checking testbench for the input terminal function logic.
`timescale 1ns/100ps
`default_nettype none
module itf_input_logic_test;
    logic        clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, rd_d;
    logic        pready_o, pslverr_o, rd_e, run_cond_i = 0, brake_trig_i = 0;
    logic [6:0]  cl = '0, lv;
    logic [2:0]  main_source_o;
    logic        run_allowed_o, reverse_allowed_o, brake_o, irq_o;
    logic        material_cutoff_fault_o, wiring_detect_fault_o;
    int          n_errors = 0, num_checks = 0;
    always #12.5 clk_i = ~clk_i;
    itf_switch_model u_itf_switch_model (.closed_i(cl), .level_o(lv));
    itf_input_logic u_itf_input_logic (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .contact_input_one_i(lv[0]),
        .contact_input_two_i(lv[1]), .contact_input_three_i(lv[2]), .contact_input_four_i(lv[3]),
        .contact_input_five_i(lv[4]), .analog_input_one_i(lv[5]), .analog_input_two_i(lv[6]),
        .run_cond_i, .brake_trig_i, .main_source_o, .run_allowed_o, .reverse_allowed_o,
        .brake_o, .material_cutoff_fault_o, .wiring_detect_fault_o, .irq_o);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        rd_d = prdata_o;
        rd_e = pslverr_o;
        psel_i <= 0; penable_i <= 0;
        // One idle cycle, so that a following call never drives psel twice in one step.
        @(posedge clk_i);
    endtask : xfer
    task automatic setf(input int i, input logic [7:0] f);
        xfer(1, itf_pkg::ADDR_FUNC_BASE + 12'(4 * i), {24'h0, f});
    endtask : setf
    // Every terminal change needs two edges to reach the outputs; three leaves margin.
    task automatic drive(input logic [6:0] c);
        cl <= c;
        repeat (3) @(posedge clk_i);
    endtask : drive
    task automatic rv(input logic [31:0] ctl, input logic [6:0] c, input logic e);
        xfer(1, itf_pkg::ADDR_CTRL, ctl);
        drive(c);
        chk("reverse_allowed", 32'(reverse_allowed_o), 32'(e));
    endtask : rv
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////
    task automatic s_regs;
        xfer(0, itf_pkg::ADDR_POL_CONTACT, 0);
        chk("pol_contact", rd_d, 32'h0);
        xfer(0, itf_pkg::ADDR_POL_ANALOG, 0);
        chk("pol_analog", rd_d, 32'h0);
        xfer(0, 12'h03c, 0);
        chk("unmapped_err", 32'(rd_e), 32'h1);
    endtask : s_regs
    task automatic s_cutoff;
        setf(0, itf_pkg::FN_CUTOFF);
        xfer(1, itf_pkg::ADDR_IRQ_MASK, 32'h1);
        xfer(1, itf_pkg::ADDR_CTRL, 32'h400);
        drive(7'h00);
        chk("cutoff_open", 32'(material_cutoff_fault_o), 32'h0);
        xfer(1, itf_pkg::ADDR_POL_CONTACT, 32'h1);
        drive(7'h00);
        chk("cutoff_inv", 32'(material_cutoff_fault_o), 32'h1);
        chk("irq_cutoff", 32'(irq_o), 32'h1);
        xfer(1, itf_pkg::ADDR_POL_CONTACT, 32'h0);
        drive(7'h00);
        xfer(1, itf_pkg::ADDR_IRQ_STAT, 32'h1);
        drive(7'h00);
        chk("cutoff_clr", 32'(material_cutoff_fault_o), 32'h0);
        chk("irq_clr", 32'(irq_o), 32'h0);
        setf(0, 8'h00);
    endtask : s_cutoff
    task automatic s_source;
        setf(1, itf_pkg::FN_SRC_AI2);
        setf(2, itf_pkg::FN_SRC_AI1);
        xfer(1, itf_pkg::ADDR_CTRL, 32'h10 | 32'(itf_pkg::SRC_COMM));
        drive(7'h06);
        chk("src_both", 32'(main_source_o), 32'(itf_pkg::SRC_AI1));
        drive(7'h02);
        chk("src_ai2", 32'(main_source_o), 32'(itf_pkg::SRC_AI2));
        xfer(1, itf_pkg::ADDR_CTRL, 32'h30 | 32'(itf_pkg::SRC_COMM));
        drive(7'h02);
        chk("src_multi", 32'(main_source_o), 32'(itf_pkg::SRC_COMM));
        xfer(1, itf_pkg::ADDR_CTRL, 32'h10 | 32'(itf_pkg::SRC_AI2));
        setf(0, itf_pkg::FN_SRC_DIGITAL);
        setf(3, itf_pkg::FN_SRC_COMM);
        drive(7'h0f);
        chk("src_digital", 32'(main_source_o), 32'(itf_pkg::SRC_DIGITAL));
        drive(7'h08);
        chk("src_comm", 32'(main_source_o), 32'(itf_pkg::SRC_COMM));
        setf(0, 8'h00);
        setf(3, 8'h00);
        setf(1, 8'h00);
        setf(2, 8'h00);
    endtask : s_source
    task automatic s_run;
        run_cond_i <= 1;
        drive(7'h00);
        chk("run_none", 32'(run_allowed_o), 32'h1);
        setf(3, itf_pkg::FN_RUN_ENABLE);
        drive(7'h00);
        chk("run_one_open", 32'(run_allowed_o), 32'h0);
        setf(4, itf_pkg::FN_RUN_ENABLE);
        drive(7'h08);
        chk("run_and", 32'(run_allowed_o), 32'h0);
        drive(7'h18);
        chk("run_all", 32'(run_allowed_o), 32'h1);
        run_cond_i <= 0;
        drive(7'h18);
        chk("run_cond", 32'(run_allowed_o), 32'h0);
    endtask : s_run
    task automatic s_rev;
        setf(5, itf_pkg::FN_REV_PROHIBIT);
        setf(6, itf_pkg::FN_REV_OVERRIDE);
        rv(32'h100, 7'h60, 1'b1);
        rv(32'h100, 7'h20, 1'b0);
        rv(32'h140, 7'h40, 1'b1);
        rv(32'h200, 7'h60, 1'b0);
        rv(32'h200, 7'h20, 1'b1);
        rv(32'h000, 7'h20, 1'b0);
        rv(32'h040, 7'h00, 1'b0);
        rv(32'h000, 7'h00, 1'b1);
    endtask : s_rev
    task automatic s_brake;
        setf(0, itf_pkg::FN_BRAKE_RESET);
        xfer(1, itf_pkg::ADDR_IRQ_MASK, 32'h4);
        brake_trig_i <= 1;
        @(posedge clk_i);
        brake_trig_i <= 0;
        drive(7'h00);
        chk("brake_set", 32'(brake_o), 32'h1);
        drive(7'h01);
        chk("brake_reset", 32'(brake_o), 32'h0);
        drive(7'h00);
        chk("irq_brake", 32'(irq_o), 32'h1);
        xfer(1, itf_pkg::ADDR_IRQ_STAT, 32'h4);
        drive(7'h00);
        chk("irq_w1c", 32'(irq_o), 32'h0);
    endtask : s_brake
    task automatic s_wiring;
        setf(1, itf_pkg::FN_WIRING);
        xfer(1, itf_pkg::ADDR_WIRE_VALID, 32'h5);
        drive(7'h02);
        chk("wire_early", 32'(wiring_detect_fault_o), 32'h0);
        repeat (8) @(posedge clk_i);
        chk("wire_expired", 32'(wiring_detect_fault_o), 32'h1);
    endtask : s_wiring
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        s_regs;
        s_cutoff;
        s_source;
        s_run;
        s_rev;
        s_brake;
        s_wiring;
        stop_test;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        stop_test;
    end
endmodule : itf_input_logic_test
`default_nettype wire
